// >>> hw/acs_conv_timer.sv
// conversion timer: powers up, acquires and converts for a fixed time
// assumes start and abort are one-cycle pulses on sys_clk
`timescale 1ns/10ps
`default_nettype none
`include "acs_params.svh"
module acs_conv_timer
  import acs_pkg::*;
#(
  parameter int CONV_CYC = (`ACS_CONV_NS * `ACS_CLK_MHZ + 999) / 1000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  acs_conv_if.core conv
);

  logic [15:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic [2:0] ch_ff, nxt_ch;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_ch = ch_ff;
    if (conv.abort) begin
      nxt_busy = 1'b0;
      nxt_cnt = 16'h0000;
    end else if (conv.start) begin
      // a new start restarts the timer on the new channel
      nxt_busy = 1'b1;
      nxt_ch = conv.ch;
      nxt_cnt = 16'(CONV_CYC - 1);
    end else if (busy_ff) begin
      if (cnt_ff == 16'h0000) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ch_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      ch_ff <= nxt_ch;
    end
  end

  assign conv.busy = busy_ff;
  assign conv.done = done_ff;
  assign conv.busy_ch = ch_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_busy_after_start: assert property (
    conv.start && !conv.abort |=> busy_ff && ch_ff == $past(conv.ch))
    else $error("timer not busy after start");
  a_done_ends_busy: assert property (done_ff |-> !busy_ff)
    else $error("done while still busy");

endmodule
`default_nettype wire

// >>> hw/adc_conversion_sequencer.sv
// conversion trigger and channel sequencing for an 8-input converter
// assumes a serial protocol engine on sys_clk that flags pointer byte,
// register writes, read phases, stop and nack; scl/sda are raw pins
//
// Function
// - Upper pointer nibble 0000 means none, 1000..1111 pick input 1..8, 0111 runs the enabled sequence.
// - A pointer whose low four bits are zero makes the next read return the conversion result.
// - The interval timer is eight bits and only its low three bits choose the interval.
// - A nonzero interval code gives one conversion per period, seven codes seven periods.
// - In automatic mode the converter powers down after each conversion until the next is due.
// - Automatic mode stops only when zero is written to the interval field.
// - Automatic mode converts one enabled channel per interval, lowest first, ascending.
// - After the highest enabled channel it wraps to the lowest and keeps looping.
// - A select code of 1000..1111 or 0111 starts power-up on the fifth falling scl edge of the pointer byte.
// - A command sequence converts the next channel during a read and stops on stop or nack.
// - A read during a running command conversion holds scl low in the ack until it completes.
// - Enable bit 0 selects input 1 and each higher bit the next input.
`timescale 1ns/10ps
`default_nettype none
`include "acs_params.svh"
module adc_conversion_sequencer
  import acs_pkg::*;
#(
  parameter int MS_CYC = `ACS_MS_NS * `ACS_CLK_MHZ / 1000,
  // period in ms per interval code, index 0 unused
  parameter logic [7:0][7:0] IVL_MS = {8'h40, 8'h20, 8'h10, 8'h08,
                                        8'h04, 8'h02, 8'h01, 8'h00}
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic ptr_active,
  input wire logic ptr_wr,
  input wire logic [7:0] ptr_wdata,
  input wire logic timer_wr,
  input wire logic [7:0] timer_wdata,
  output logic [7:0] timer_rdata,
  input wire logic [7:0] cfg_ch_en,
  input wire logic rd_ack,
  input wire logic result_rd,
  input wire logic stop_det,
  input wire logic nack_det,
  output logic result_ptr_sel,
  output logic powered_up,
  output logic [2:0] conv_ch,
  output logic conv_done
);

  acs_conv_if conv ();

  acs_conv_timer u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .conv(conv.core)
  );

  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] fcnt_ff, nxt_fcnt;
  logic ptr_res_ff, nxt_ptr_res;
  logic [7:0] timer_ff, nxt_timer;
  acs_mode_e mode_ff, nxt_mode;
  logic [2:0] cur_ch_ff, nxt_cur_ch;
  logic [2:0] auto_last_ff, nxt_auto_last;
  logic [31:0] ms_cnt_ff, nxt_ms_cnt;
  logic [7:0] ivl_cnt_ff, nxt_ivl_cnt;
  logic start_ff, nxt_start;
  logic abort_ff, nxt_abort;
  logic hold_ff, nxt_hold;
  logic fall, rise, pwr_edge, due;
  logic [3:0] cmd;
  logic [2:0] ivl;
  acs_pick_s pick;

  // second and third stages feed the edge detector; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  assign fall = scl_s3 & ~scl_s2;
  assign rise = ~scl_s3 & scl_s2;
  // at the fifth fall five bits are in, so the nibble sits in shift_ff[4:1]
  assign pwr_edge = fall && ptr_active && fcnt_ff == `ACS_PWRUP_FALL;
  assign cmd = shift_ff[4:1];
  assign ivl = timer_ff[`ACS_IVL_MSB:0];
  assign due = ivl != 3'h0 && ms_cnt_ff == 32'h0
               && ivl_cnt_ff + 8'h01 >= IVL_MS[ivl];

  always_comb begin
    nxt_shift = shift_ff;
    nxt_fcnt = fcnt_ff;
    nxt_ptr_res = ptr_res_ff;
    nxt_timer = timer_ff;
    nxt_mode = mode_ff;
    nxt_cur_ch = cur_ch_ff;
    nxt_auto_last = auto_last_ff;
    nxt_ms_cnt = ms_cnt_ff;
    nxt_ivl_cnt = ivl_cnt_ff;
    nxt_start = 1'b0;
    nxt_abort = 1'b0;
    nxt_hold = hold_ff;
    pick = '0;

    if (!ptr_active) begin
      nxt_fcnt = 4'h0;
    end else begin
      if (rise) begin
        nxt_shift = {shift_ff[6:0], sda_s2};
      end
      if (fall && fcnt_ff != 4'h8) begin
        nxt_fcnt = fcnt_ff + 4'h1;
      end
    end
    if (ptr_wr) begin
      nxt_ptr_res = ptr_wdata[3:0] == `ACS_PTR_RESULT;
    end

    // interval timebase: 1 ms enable, then count whole periods
    if (ivl == 3'h0 || ms_cnt_ff == 32'h0) begin
      nxt_ms_cnt = 32'(MS_CYC - 1);
    end else begin
      nxt_ms_cnt = ms_cnt_ff - 32'h1;
    end
    if (ivl != 3'h0 && ms_cnt_ff == 32'h0) begin
      nxt_ivl_cnt = due ? 8'h00 : ivl_cnt_ff + 8'h01;
    end

    if (mode_ff == ACS_CMD || mode_ff == ACS_AUTO) begin
      if (conv.done) begin
        nxt_mode = ACS_IDLE;
      end
    end

    if (due && mode_ff == ACS_IDLE && !conv.busy) begin
      // bit i of the enable field is input i+1
      pick = acs_next_en(cfg_ch_en, int'(auto_last_ff), 1'b1);
      if (pick.found) begin
        nxt_start = 1'b1;
        nxt_cur_ch = pick.ch;
        nxt_auto_last = pick.ch;
        nxt_mode = ACS_AUTO;
      end
    end

    if (mode_ff == ACS_SEQ && result_rd && !conv.busy) begin
      pick = acs_next_en(cfg_ch_en, int'(cur_ch_ff), 1'b0);
      if (pick.found) begin
        nxt_start = 1'b1;
        nxt_cur_ch = pick.ch;
      end
    end

    if (pwr_edge) begin
      if (cmd[3]) begin
        nxt_start = 1'b1;
        nxt_cur_ch = cmd[2:0];
        nxt_mode = ACS_CMD;
      end else if (cmd == `ACS_CMD_SEQ) begin
        pick = acs_next_en(cfg_ch_en, -1, 1'b0);
        if (pick.found) begin
          nxt_start = 1'b1;
          nxt_cur_ch = pick.ch;
          nxt_mode = ACS_SEQ;
        end
      end
    end

    if ((stop_det || nack_det) && (mode_ff == ACS_CMD || mode_ff == ACS_SEQ)
        && !pwr_edge) begin
      nxt_mode = ACS_IDLE;
      nxt_abort = 1'b1;
      nxt_start = 1'b0;
    end

    if (timer_wr) begin
      nxt_timer = timer_wdata;
      if (timer_wdata[`ACS_IVL_MSB:0] == 3'h0) begin
        // leaving automatic mode restarts the loop at the lowest channel
        nxt_auto_last = `ACS_LAST_CH;
        nxt_ivl_cnt = 8'h00;
      end
    end

    // stretch only while a command conversion is still running
    if (hold_ff) begin
      nxt_hold = conv.busy;
    end else begin
      nxt_hold = rd_ack && conv.busy
                 && (mode_ff == ACS_CMD || mode_ff == ACS_SEQ);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= 8'h00;
      fcnt_ff <= 4'h0;
      ptr_res_ff <= 1'b0;
      timer_ff <= `ACS_TIMER_RST;
      mode_ff <= ACS_IDLE;
      cur_ch_ff <= 3'h0;
      auto_last_ff <= `ACS_LAST_CH;
      ms_cnt_ff <= 32'h0;
      ivl_cnt_ff <= 8'h00;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      fcnt_ff <= nxt_fcnt;
      ptr_res_ff <= nxt_ptr_res;
      timer_ff <= nxt_timer;
      mode_ff <= nxt_mode;
      cur_ch_ff <= nxt_cur_ch;
      auto_last_ff <= nxt_auto_last;
      ms_cnt_ff <= nxt_ms_cnt;
      ivl_cnt_ff <= nxt_ivl_cnt;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
      hold_ff <= nxt_hold;
    end
  end

  assign conv.start = start_ff;
  assign conv.abort = abort_ff;
  assign conv.ch = cur_ch_ff;
  assign scl_out = 1'b0;
  assign scl_oe = hold_ff;
  assign timer_rdata = timer_ff;
  assign result_ptr_sel = ptr_res_ff;
  assign powered_up = conv.busy;
  assign conv_ch = conv.busy_ch;
  assign conv_done = conv.done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ptr_result_sel: assert property (
    ptr_wr |=> result_ptr_sel == ($past(ptr_wdata[3:0]) == 4'h0))
    else $error("result pointer select wrong");
  a_timer_store: assert property (
    timer_wr |=> timer_rdata == $past(timer_wdata))
    else $error("interval timer not stored");
  a_fifth_fall_start: assert property (
    pwr_edge && cmd[3] && !stop_det && !nack_det
    |=> start_ff && cur_ch_ff == $past(shift_ff[3:1]) ##1 powered_up)
    else $error("no power-up on fifth falling edge");
  a_seq_lowest: assert property (
    pwr_edge && cmd == 4'h7 && cfg_ch_en == 8'h26 && !stop_det && !nack_det
    |=> start_ff && cur_ch_ff == 3'h1)
    else $error("sequence does not start at lowest channel");
  a_auto_enabled: assert property (
    start_ff && mode_ff == ACS_AUTO |-> timer_ff[2:0] != 3'h0
    && cfg_ch_en[cur_ch_ff])
    else $error("automatic start on disabled channel or zero interval");
  a_auto_powerdown: assert property (
    mode_ff == ACS_AUTO && conv.done |=> mode_ff == ACS_IDLE && !powered_up)
    else $error("no power-down after automatic conversion");
  a_stop_ends_seq: assert property (
    (stop_det || nack_det) && mode_ff == ACS_SEQ && !pwr_edge
    |=> mode_ff == ACS_IDLE ##1 !powered_up)
    else $error("sequence not stopped by stop or nack");
  a_scl_hold: assert property (
    hold_ff && !conv.busy |=> !scl_oe)
    else $error("scl held after conversion end");
  a_zero_interval: assert property (
    timer_ff[2:0] == 3'h0 |=> !(start_ff && mode_ff == ACS_AUTO))
    else $error("interval due with zero code");

  c_cmd_single: cover property (pwr_edge && cmd[3] ##[1:300] conv_done);
  c_auto_wrap: cover property (
    start_ff && mode_ff == ACS_AUTO && auto_last_ff == 3'h0);
  c_scl_stretch: cover property ($rose(scl_oe) ##[1:200] $fell(scl_oe));

endmodule
`default_nettype wire

// >>> include/acs_conv_if.sv
// carrier between the sequencer and the conversion timer
// assumes both ends run on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface acs_conv_if;
  logic start;
  logic abort;
  logic [2:0] ch;
  logic busy;
  logic done;
  logic [2:0] busy_ch;

  modport ctl (output start, output abort, output ch,
               input busy, input done, input busy_ch);
  modport core (input start, input abort, input ch,
                output busy, output done, output busy_ch);
endinterface
`default_nettype wire

// >>> include/acs_params.svh
// constants for the conversion sequencer: codes, field positions, timing
// assumes inclusion by both design modules; holds definitions only
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_CMD_NONE 4'h0
`define ACS_CMD_SEQ 4'h7
`define ACS_PTR_RESULT 4'h0
`define ACS_PWRUP_FALL 4'h4
`define ACS_IVL_MSB 2
`define ACS_TIMER_RST 8'h00
`define ACS_LAST_CH 3'h7
`define ACS_CLK_MHZ 50
`define ACS_CONV_NS 3000
`define ACS_MS_NS 1000000

`endif

// >>> include/acs_pkg.sv
// types and the channel search shared by the sequencer modules
// assumes nothing of its surroundings
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_CMD  = 2'b01,
    ACS_SEQ  = 2'b10,
    ACS_AUTO = 2'b11
  } acs_mode_e;

  typedef struct packed {
    logic       found;
    logic [2:0] ch;
  } acs_pick_s;

  // lowest enabled channel above 'after'; with wrap, falls back to lowest
  function automatic acs_pick_s acs_next_en(input logic [7:0] en,
                                            input int after,
                                            input logic wrap);
    acs_pick_s p;
    p.found = 1'b0;
    p.ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && i > after) begin
        p.found = 1'b1;
        p.ch = 3'(i);
      end
    end
    if (!p.found && wrap) begin
      for (int i = 7; i >= 0; i--) begin
        if (en[i]) begin
          p.found = 1'b1;
          p.ch = 3'(i);
        end
      end
    end
    return p;
  endfunction

endpackage

// >>> verification/acs_bus_master.sv
// two-wire master model: clocks one pointer byte onto the raw pins
// assumes the bench's sys_clk; scl and sda idle high through pull-ups
`timescale 1ns/10ps
`default_nettype none
module acs_bus_master (
  input wire logic sys_clk,
  output logic scl,
  output logic sda,
  output logic ptr_active,
  output logic ptr_wr,
  output logic [7:0] ptr_wdata,
  output int falls
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    ptr_active = 1'b0;
    ptr_wr = 1'b0;
    ptr_wdata = 8'h00;
    falls = 0;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  // 160 ns serial clock: four sys_clk low, four high; msb first
  task automatic send_ptr(input logic [7:0] b);
    falls = 0;
    // the address acknowledge leaves scl low before the first data bit
    scl = 1'b0;
    tick(4);
    ptr_active = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      tick(4);
      scl = 1'b1;
      tick(4);
      scl = 1'b0;
      falls = 8 - i;
    end
    // released data line floats back up, never keeps the last bit
    sda = 1'b1;
    tick(4);
    scl = 1'b1;
    ptr_wdata = b;
    ptr_wr = 1'b1;
    tick(1);
    ptr_wr = 1'b0;
    tick(4);
    ptr_active = 1'b0;
    tick(1);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// bench for the conversion sequencer: commands, sequences, stretch, timer
// assumes the master model drives scl/sda; the bench plays the engine
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int MS = 10;
  logic sys_clk, nrst, m_scl, sda_in, ptr_active, ptr_wr, timer_wr;
  logic rd_ack, result_rd, stop_det, nack_det;
  logic [7:0] ptr_wdata, timer_wdata, cfg_ch_en, timer_rdata;
  logic scl_out, scl_oe, result_ptr_sel, powered_up, conv_done;
  logic [2:0] conv_ch;
  int falls, errors, compares, n;
  wire logic scl_in;
  // open drain: the device can only pull the line low
  assign scl_in = m_scl & ~(scl_oe & ~scl_out);

  acs_bus_master i_acs_bus_master (.sys_clk(sys_clk), .scl(m_scl),
    .sda(sda_in), .ptr_active(ptr_active), .ptr_wr(ptr_wr),
    .ptr_wdata(ptr_wdata), .falls(falls));
  adc_conversion_sequencer #(.MS_CYC(MS)) i_adc_conversion_sequencer (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .ptr_active(ptr_active),
    .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .timer_wr(timer_wr),
    .timer_wdata(timer_wdata), .timer_rdata(timer_rdata),
    .cfg_ch_en(cfg_ch_en), .rd_ack(rd_ack), .result_rd(result_rd),
    .stop_det(stop_det), .nack_det(nack_det),
    .result_ptr_sel(result_ptr_sel), .powered_up(powered_up),
    .conv_ch(conv_ch), .conv_done(conv_done));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // 0 ack after read address, 1 result read, 2 stop, 3 nack
  task automatic pulse(input int k);
    case (k)
      0: rd_ack = 1'b1;
      1: result_rd = 1'b1;
      2: stop_det = 1'b1;
      default: nack_det = 1'b1;
    endcase
    tick(1);
    {rd_ack, result_rd, stop_det, nack_det} = 4'h0;
  endtask

  task automatic wr_timer(input logic [7:0] v);
    timer_wdata = v;
    timer_wr = 1'b1;
    tick(1);
    timer_wr = 1'b0;
    tick(1);
  endtask

  // counts cycles until the end-of-conversion pulse, at most lim
  task automatic wait_done(input int lim);
    n = 0;
    while (conv_done !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic cmd(input logic [7:0] b, input logic on);
    fork
      i_acs_bus_master.send_ptr(b);
      begin
        wait (falls == 5);
        chk("early", 16'h0, 16'(powered_up));
        wait (falls == 6);
        chk("pwr", 16'(on), 16'(powered_up));
      end
    join
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    test_done;
  end

  initial begin
    {nrst, timer_wr, rd_ack, result_rd, stop_det} = 5'h00;
    {nack_det, timer_wdata, cfg_ch_en} = 17'h00000;
    tick(12);
    nrst = 1'b1;
    chk("rdata", 16'h0, 16'(timer_rdata));
    chk("oe", 16'h0, 16'(scl_oe));
    for (int c = 8; c < 16; c++) begin
      cmd({4'(c), 4'h0}, 1'b1);
      chk("psel", 16'h1, 16'(result_ptr_sel));
      chk("ch", 16'(c - 8), 16'(conv_ch));
      wait_done(300);
      chk("done", 16'h1, 16'(conv_done));
      tick(1);
    end
    for (int c = 0; c < 7; c++) begin
      cmd({4'(c), 4'h1}, 1'b0);
      chk("psel", 16'h0, 16'(result_ptr_sel));
    end
    cfg_ch_en = 8'h26;
    cmd(8'h70, 1'b1);
    chk("ch", 16'h1, 16'(conv_ch));
    for (int k = 2; k < 6; k += 3) begin
      wait_done(300);
      pulse(1);
      tick(2);
      chk("next", 16'h1, 16'(powered_up));
      chk("ch", 16'(k), 16'(conv_ch));
    end
    wait_done(300);
    pulse(1);
    tick(3);
    chk("nowrap", 16'h0, 16'(powered_up));
    for (int k = 2; k < 4; k++) begin
      cmd(8'h70, 1'b1);
      pulse(k);
      tick(3);
      chk("abort", 16'h0, 16'(powered_up));
      pulse(1);
      tick(3);
      chk("halt", 16'h0, 16'(powered_up));
    end
    cmd(8'h80, 1'b1);
    pulse(0);
    tick(1);
    chk("hold", 16'h1, 16'(scl_oe));
    chk("sclo", 16'h0, 16'(scl_out));
    wait_done(300);
    tick(2);
    chk("rel", 16'h0, 16'(scl_oe));
    pulse(2);
    cfg_ch_en = 8'h81;
    wr_timer(8'h07);
    chk("rdata", 16'h7, 16'(timer_rdata));
    wait_done(1500);
    chk("ch", 16'h0, 16'(conv_ch));
    tick(1);
    chk("down", 16'h0, 16'(powered_up));
    wait_done(1500);
    chk("gap", 16'(64 * MS - 1), 16'(n));
    chk("ch", 16'h7, 16'(conv_ch));
    tick(1);
    wait_done(1500);
    chk("wrap", 16'h0, 16'(conv_ch));
    wr_timer(8'h00);
    chk("rdata", 16'h00, 16'(timer_rdata));
    wait_done(1500);
    chk("off", 16'd1500, 16'(n));
    cfg_ch_en = 8'h00;
    wr_timer(8'h01);
    wait_done(1500);
    chk("none", 16'd1500, 16'(n));
    wr_timer(8'h00);
    test_done;
  end
endmodule
`default_nettype wire
